/* File: verilog/reset_power_pkg.sv */
package reset_power_pkg;

	// register byte addresses on the peripheral bus
	localparam logic [7:0] ADDR_STOP_KEY = 8'h00;
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h04;
	localparam logic [7:0] ADDR_INT_MASK = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;

	// stop key that arms the stop instruction
	localparam logic [7:0] STOP_KEY_VALUE = 8'hA5;
	localparam logic [7:0] STOP_KEY_RESET = 8'h00;

	// clock divider field inside clock_divider_control, 2'b00 selects osc/16
	localparam int CLKDIV_LSB = 3;
	localparam int CLKDIV_MSB = 4;
	localparam logic [1:0] CLKDIV_RESET = 2'h0;

	localparam logic [7:0] INT_MASK_RESET = 8'h00;

	// option byte address and the detector / power-on selection bit in it
	localparam logic [15:0] OPTION_BYTE_ADDR = 16'h003F;
	localparam int OPTION_LVD_BIT = 7;

	localparam logic [7:0] IDLE_OPCODE = 8'h6F;

	// reset pulse held for the oscillator stabilisation interval
	localparam int RESET_HOLD_CYCLES = 16;

	// status register fields
	localparam int ST_MODE_LSB = 0;
	localparam int ST_OPTION_BIT = 2;
	localparam int ST_CAUSE_LSB = 8;

	// reset cause bit positions
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_LVD = 1;
	localparam int CAUSE_INTERNAL_POWER_ON_RESET = 2;
	localparam int CAUSE_EXTINT = 3;
	localparam int CAUSE_SED = 4;
	localparam int CAUSE_WDT = 5;
	localparam int CAUSE_W = 6;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_STOP,
		MODE_BACKUP
	} pd_mode_t;

endpackage

/* File: verilog/reset_power_ctrl.sv */
// How it works
// - option bit one keeps the low-voltage detector alive in all modes, stop included.
// - option bit zero blocks detector resets while in stop.
// - option zero in stop: an enabled external interrupt gives a system reset.
// - option zero in stop or abnormal: falling port edge gives a system reset.
// - option one in stop: supply rising through threshold with pin high resets.
// - reset pin rising resets only while supply is at or above threshold.
// - option zero in stop: power-on reset only for rise from below 0.4.
// - option bit is bit 7 of the option byte at 003FH.
// - idle opcode stops the cpu clock, listed peripherals keep clocking.
// - port directions are held as they were during idle.
// - reset ending idle restores control defaults and slowest clock, osc/16.
// - with every interrupt masked only a reset ends idle.
// - enabled interrupt ends idle and leaves the divider field unchanged.
// - option one: enabled external interrupt pins or a falling port edge wake stop; idle takes any unmasked level interrupt.
// - low pin, or supply falling through threshold while the detector is on, enters back-up.
// - back-up ends only on a pin or detector system reset.
// - watchdog resets are ignored during back-up.
// - software writes the stop key then stop halts oscillator and cpu.
// - stop is entered only with the key holding 0A5H.
// - stop ends on reset or external interrupt and clears the key.
// - option one: external interrupt in stop only wakes, no reset.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps

module reset_power_ctrl
	import reset_power_pkg::*;
#(
	parameter int N_EXT_INT = 10,
	parameter int N_INT_LEVEL = 8,
	parameter int ADDR_W = 8,
	parameter logic [7:0] STOP_OPCODE = 8'h7F
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] option_byte,
	input wire logic op_valid,
	input wire logic [7:0] op_code,
	input wire logic vdd_above_lvd,
	input wire logic vdd_above_por_floor,
	input wire logic reset_pin_low_active,
	input wire logic abnormal_state,
	input wire logic wdt_overflow,
	input wire logic [N_EXT_INT-1:0] ext_int_req,
	input wire logic [N_EXT_INT-1:0] ext_int_en,
	input wire logic [N_INT_LEVEL-1:0] int_level_req,
	input wire logic [7:0] port0_in,
	input wire logic [3:0] port2_hi_in,
	output logic sys_reset,
	output logic cpu_wake,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_en,
	output logic lvd_enable,
	output logic internal_power_on_reset_enable,
	output logic port_dir_hold,
	output logic [1:0] clkdiv_sel,
	output reset_power_pkg::pd_mode_t mode
);
	import reset_power_pkg::*;

	function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] r);
		is_reg = (a == ADDR_W'(r));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// option capture and input history

	logic opt_lvd_r, opt_lvd_nxt;
	logic opt_done_r, opt_done_nxt;
	logic vdd_prev_r, vdd_prev_nxt;
	logic pin_prev_r, pin_prev_nxt;
	logic [11:0] port_prev_r, port_prev_nxt;
	logic [11:0] port_now;

	assign port_now = {port2_hi_in, port0_in};

	// option byte is a strap: caught on the first enabled edge after release
	always_comb begin
		opt_lvd_nxt = opt_lvd_r;
		opt_done_nxt = opt_done_r;
		if (!opt_done_r) begin
			opt_lvd_nxt = option_byte[OPTION_LVD_BIT];
			opt_done_nxt = 1'b1;
		end
		vdd_prev_nxt = vdd_above_lvd;
		pin_prev_nxt = reset_pin_low_active;
		port_prev_nxt = port_now;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_lvd_r <= 1'b0;
			opt_done_r <= 1'b0;
			// history starts at idle levels so release alone fakes no edge
			vdd_prev_r <= 1'b1;
			pin_prev_r <= 1'b1;
			port_prev_r <= 12'hFFF;
		end else if (ce) begin
			opt_lvd_r <= opt_lvd_nxt;
			opt_done_r <= opt_done_nxt;
			vdd_prev_r <= vdd_prev_nxt;
			pin_prev_r <= pin_prev_nxt;
			port_prev_r <= port_prev_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset sources

	pd_mode_t mode_r, mode_nxt;
	logic [4:0] rst_cnt_r, rst_cnt_nxt;
	logic internal_power_on_reset_armed_r, internal_power_on_reset_armed_nxt;
	logic sys_reset_r, sys_reset_nxt;
	logic wake_r, wake_nxt;
	logic [7:0] stop_key_r;
	logic [1:0] clkdiv_r;
	logic [N_INT_LEVEL-1:0] imask_r;

	logic in_stop, lvd_active, vdd_rise, pin_rise, port_fall, ext_hit;
	logic rst_pin, rst_lvd, rst_internal_power_on_reset, rst_ext, rst_sed, rst_wdt;
	logic rst_req, backup_entry, idle_wake, stop_wake, stop_go, stop_leave;
	logic [CAUSE_W-1:0] cause_vec;

	assign in_stop = (mode_r == MODE_STOP);
	assign lvd_active = opt_lvd_r || !in_stop;
	assign vdd_rise = vdd_above_lvd && !vdd_prev_r;
	assign pin_rise = reset_pin_low_active && !pin_prev_r;
	assign port_fall = |(port_prev_r & ~port_now);
	assign ext_hit = |(ext_int_req & ext_int_en);

	assign rst_pin = pin_rise && vdd_above_lvd;
	assign rst_lvd = lvd_active && vdd_rise && reset_pin_low_active;
	// power-on source only counts a rise that began below the 0.4 floor
	assign rst_internal_power_on_reset = !opt_lvd_r && in_stop && vdd_rise && internal_power_on_reset_armed_r
		&& reset_pin_low_active;
	assign rst_ext = !opt_lvd_r && in_stop && ext_hit;
	assign rst_sed = !opt_lvd_r && (in_stop || abnormal_state) && port_fall;
	assign rst_wdt = wdt_overflow && (mode_r != MODE_BACKUP);

	// in back-up only the pin and the detector may release the chip
	assign rst_req = (mode_r == MODE_BACKUP) ? (rst_pin || rst_lvd)
		: (rst_pin || rst_lvd || rst_internal_power_on_reset || rst_ext || rst_sed || rst_wdt);

	// with the detector off in stop a sagging supply does not enter back-up
	assign backup_entry = !reset_pin_low_active
		|| (lvd_active && !vdd_above_lvd);

	assign idle_wake = |(int_level_req & imask_r);
	assign stop_wake = opt_lvd_r && (ext_hit || port_fall);
	assign stop_go = op_valid && (op_code == STOP_OPCODE)
		&& (stop_key_r == STOP_KEY_VALUE) && !abnormal_state;

	always_comb begin
		cause_vec = '0;
		cause_vec[CAUSE_PIN] = rst_pin;
		cause_vec[CAUSE_LVD] = rst_lvd;
		cause_vec[CAUSE_INTERNAL_POWER_ON_RESET] = rst_internal_power_on_reset;
		cause_vec[CAUSE_EXTINT] = rst_ext;
		cause_vec[CAUSE_SED] = rst_sed;
		cause_vec[CAUSE_WDT] = rst_wdt;
	end

	////////////////////////////////////////////////////////////////////////
	// power mode sequencer

	always_comb begin
		mode_nxt = mode_r;
		rst_cnt_nxt = rst_cnt_r;
		wake_nxt = 1'b0;
		internal_power_on_reset_armed_nxt = internal_power_on_reset_armed_r;
		if (in_stop && !opt_lvd_r && !vdd_above_por_floor)
			internal_power_on_reset_armed_nxt = 1'b1;
		if (backup_entry) begin
			mode_nxt = MODE_BACKUP;
			rst_cnt_nxt = 5'h00;
			internal_power_on_reset_armed_nxt = 1'b0;
		end else if (rst_req) begin
			// merged sources restart the whole hold interval
			mode_nxt = MODE_RUN;
			rst_cnt_nxt = 5'(RESET_HOLD_CYCLES);
			internal_power_on_reset_armed_nxt = 1'b0;
		end else if (rst_cnt_r != 5'h00) begin
			rst_cnt_nxt = rst_cnt_r - 5'h01;
		end else begin
			case (mode_r)
				MODE_RUN: begin
					if (op_valid && op_code == IDLE_OPCODE)
						mode_nxt = MODE_IDLE;
					else if (stop_go)
						mode_nxt = MODE_STOP;
				end
				MODE_IDLE: begin
					if (idle_wake) begin
						mode_nxt = MODE_RUN;
						wake_nxt = 1'b1;
					end
				end
				MODE_STOP: begin
					if (stop_wake) begin
						mode_nxt = MODE_RUN;
						wake_nxt = 1'b1;
						internal_power_on_reset_armed_nxt = 1'b0;
					end
				end
				MODE_BACKUP: mode_nxt = MODE_BACKUP;
				default: mode_nxt = MODE_RUN;
			endcase
		end
		sys_reset_nxt = (rst_cnt_nxt != 5'h00);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= MODE_RUN;
			rst_cnt_r <= 5'h00;
			internal_power_on_reset_armed_r <= 1'b0;
			sys_reset_r <= 1'b0;
			wake_r <= 1'b0;
		end else if (ce) begin
			mode_r <= mode_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			internal_power_on_reset_armed_r <= internal_power_on_reset_armed_nxt;
			sys_reset_r <= sys_reset_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign stop_leave = in_stop && (mode_nxt != MODE_STOP);

	////////////////////////////////////////////////////////////////////////
	// apb register file

	logic [7:0] stop_key_nxt;
	logic [1:0] clkdiv_nxt;
	logic [N_INT_LEVEL-1:0] imask_nxt;
	logic [CAUSE_W-1:0] cause_r, cause_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic mapped, wr_en;

	assign mapped = is_reg(paddr, ADDR_STOP_KEY) || is_reg(paddr, ADDR_CLK_CTRL)
		|| is_reg(paddr, ADDR_INT_MASK) || is_reg(paddr, ADDR_STATUS);
	assign wr_en = psel && penable && pwrite && mapped;

	always_comb begin
		stop_key_nxt = stop_key_r;
		clkdiv_nxt = clkdiv_r;
		imask_nxt = imask_r;
		cause_nxt = cause_r;
		prdata_nxt = prdata_r;
		if (stop_leave)
			stop_key_nxt = STOP_KEY_RESET;
		if (wr_en && is_reg(paddr, ADDR_STOP_KEY))
			stop_key_nxt = pwdata[7:0];
		if (wr_en && is_reg(paddr, ADDR_CLK_CTRL))
			clkdiv_nxt = pwdata[CLKDIV_MSB:CLKDIV_LSB];
		if (wr_en && is_reg(paddr, ADDR_INT_MASK))
			imask_nxt = pwdata[N_INT_LEVEL-1:0];
		// a system reset returns control state to defaults, divider to osc/16
		if (!backup_entry && rst_req) begin
			stop_key_nxt = STOP_KEY_RESET;
			clkdiv_nxt = CLKDIV_RESET;
			imask_nxt = INT_MASK_RESET;
			cause_nxt = cause_vec;
		end
		if (psel && !penable) begin
			prdata_nxt = 32'h0000_0000;
			if (is_reg(paddr, ADDR_STOP_KEY))
				prdata_nxt[7:0] = stop_key_r;
			else if (is_reg(paddr, ADDR_CLK_CTRL))
				prdata_nxt[CLKDIV_MSB:CLKDIV_LSB] = clkdiv_r;
			else if (is_reg(paddr, ADDR_INT_MASK))
				prdata_nxt[N_INT_LEVEL-1:0] = imask_r;
			else if (is_reg(paddr, ADDR_STATUS)) begin
				prdata_nxt[ST_MODE_LSB +: 2] = mode_r;
				prdata_nxt[ST_OPTION_BIT] = opt_lvd_r;
				prdata_nxt[ST_CAUSE_LSB +: CAUSE_W] = cause_r;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_key_r <= STOP_KEY_RESET;
			clkdiv_r <= CLKDIV_RESET;
			imask_r <= INT_MASK_RESET;
			cause_r <= '0;
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			stop_key_r <= stop_key_nxt;
			clkdiv_r <= clkdiv_nxt;
			imask_r <= imask_nxt;
			cause_r <= cause_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// zero wait states: read data is prepared during the setup phase
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_r;

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign sys_reset = sys_reset_r;
	assign cpu_wake = wake_r;
	assign mode = mode_r;
	assign cpu_clk_en = (mode_r == MODE_RUN) && !sys_reset_r;
	// interrupt logic, timers, counter and comparator keep clock in idle
	assign periph_clk_en = (mode_r == MODE_RUN) || (mode_r == MODE_IDLE);
	assign osc_en = (mode_r == MODE_RUN) || (mode_r == MODE_IDLE);
	assign lvd_enable = lvd_active;
	assign internal_power_on_reset_enable = !lvd_active;
	assign port_dir_hold = (mode_r == MODE_IDLE);
	assign clkdiv_sel = clkdiv_r;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	stop_key_gate_a: assert property (
		ce && mode_r == MODE_RUN && rst_cnt_r == 5'h00 && !rst_req && !backup_entry
		&& op_valid && op_code == STOP_OPCODE && stop_key_r != STOP_KEY_VALUE
		|=> mode_r != MODE_STOP)
		else $error("stop entered without key");

	lvd_off_stop_a: assert property (
		!lvd_enable |-> (mode_r == MODE_STOP && !opt_lvd_r))
		else $error("detector disabled outside stop");

	ext_reset_a: assert property (
		ce && in_stop && !opt_lvd_r && ext_hit && !backup_entry |=> sys_reset)
		else $error("external interrupt in stop did not reset");

	sed_reset_a: assert property (
		ce && abnormal_state && !opt_lvd_r && port_fall && !backup_entry
		&& mode_r != MODE_BACKUP |=> sys_reset)
		else $error("port falling edge did not reset");

	pin_reset_a: assert property (
		ce && pin_rise && vdd_above_lvd && !backup_entry |=> sys_reset && mode_r == MODE_RUN)
		else $error("reset pin rise ignored");

	backup_entry_a: assert property (
		ce && !reset_pin_low_active |=> mode_r == MODE_BACKUP && !osc_en)
		else $error("low reset pin did not enter back-up");

	backup_hold_a: assert property (
		ce && mode_r == MODE_BACKUP && !rst_pin && !rst_lvd |=> !sys_reset && !cpu_wake)
		else $error("back-up released without pin or detector");

	hold_length_a: assert property (
		$rose(sys_reset) |-> sys_reset [*8])
		else $error("system reset pulse too short");

	idle_masked_a: assert property (
		ce && mode_r == MODE_IDLE && imask_r == '0 && !rst_req && !backup_entry
		&& rst_cnt_r == 5'h00 |=> mode_r == MODE_IDLE)
		else $error("idle left while fully masked");

	idle_wake_a: assert property (
		ce && mode_r == MODE_IDLE && idle_wake && !rst_req && !backup_entry && !wr_en
		&& rst_cnt_r == 5'h00 |=> mode_r == MODE_RUN && cpu_wake && $stable(clkdiv_sel))
		else $error("enabled interrupt did not end idle");

	key_clear_a: assert property (
		ce && stop_leave && !wr_en |=> stop_key_r == STOP_KEY_RESET)
		else $error("stop key not cleared on leaving stop");

	opt_wake_a: assert property (
		ce && in_stop && opt_lvd_r && ext_hit && !rst_req && !backup_entry
		&& rst_cnt_r == 5'h00 |=> mode_r == MODE_RUN && !sys_reset)
		else $error("option one external wake misbehaved");

	idle_enter_c: cover property (mode_r == MODE_RUN ##1 mode_r == MODE_IDLE ##[1:20] cpu_wake);
	stop_enter_c: cover property (mode_r == MODE_RUN ##1 mode_r == MODE_STOP);
	backup_exit_c: cover property (mode_r == MODE_BACKUP ##1 sys_reset);
	stop_reset_c: cover property (in_stop && rst_ext ##1 sys_reset);

endmodule

/* File: tb/supply_and_pin_model.sv */
`timescale 1ns/1ps

// supply level in tenths of nominal; the pin is pulled up when not asserted
module supply_and_pin_model #(
	parameter logic [7:0] LVD_LEVEL = 8'h08,
	parameter logic [7:0] POR_FLOOR = 8'h04
) (
	input wire logic [7:0] vdd_level,
	input wire logic pin_assert,
	output logic vdd_above_lvd,
	output logic vdd_above_por_floor,
	output logic reset_pin_low_active
);
	assign vdd_above_lvd = (vdd_level >= LVD_LEVEL);
	assign vdd_above_por_floor = (vdd_level >= POR_FLOOR);
	assign reset_pin_low_active = ~pin_assert;
endmodule

/* File: tb/reset_and_power_down_control_tb_top.sv */
`timescale 1ns/1ps

module reset_and_power_down_control_tb_top;
	import reset_power_pkg::*;
	localparam logic [7:0] STOP_OP = 8'h7F;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 0;
	logic abnormal_state = 0, wdt_overflow = 0, pin_assert = 0, e, seen;
	logic [7:0] paddr = 8'h00, option_byte = 8'h00, op_code = 8'h00, port0_in = 8'hFF;
	logic [7:0] vdd_level = 8'h0A, int_level_req = 8'h00;
	logic [3:0] port2_hi_in = 4'hF;
	logic [9:0] ext_int_req = 10'h000, ext_int_en = 10'h000;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic pready, pslverr, vdd_above_lvd, vdd_above_por_floor, reset_pin_low_active;
	logic sys_reset, cpu_wake, cpu_clk_en, periph_clk_en, osc_en, lvd_enable, internal_power_on_reset_enable;
	logic port_dir_hold;
	logic [1:0] clkdiv_sel;
	pd_mode_t mode;
	int err_count = 0, total_checks = 0, n;

	initial begin
		forever #12.5 pclk = ~pclk;
	end

	supply_and_pin_model supply_and_pin_model_i (.vdd_level(vdd_level), .pin_assert(pin_assert),
		.vdd_above_lvd(vdd_above_lvd), .vdd_above_por_floor(vdd_above_por_floor),
		.reset_pin_low_active(reset_pin_low_active));

	reset_power_ctrl #(.STOP_OPCODE(STOP_OP)) reset_power_ctrl_i (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.option_byte(option_byte), .op_valid(op_valid), .op_code(op_code),
		.vdd_above_lvd(vdd_above_lvd), .vdd_above_por_floor(vdd_above_por_floor),
		.reset_pin_low_active(reset_pin_low_active), .abnormal_state(abnormal_state),
		.wdt_overflow(wdt_overflow), .ext_int_req(ext_int_req), .ext_int_en(ext_int_en),
		.int_level_req(int_level_req), .port0_in(port0_in), .port2_hi_in(port2_hi_in),
		.sys_reset(sys_reset), .cpu_wake(cpu_wake), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .osc_en(osc_en), .lvd_enable(lvd_enable),
		.internal_power_on_reset_enable(internal_power_on_reset_enable), .port_dir_hold(port_dir_hold), .clkdiv_sel(clkdiv_sel),
		.mode(mode));

	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// master never assumes a latency: it loops until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int w;
		w = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 20);
		check(32'(pready), 32'h1);
		d = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task op(input logic [7:0] c);
		@(posedge pclk);
		op_valid <= 1;
		op_code <= c;
		@(posedge pclk);
		op_valid <= 0;
		@(negedge pclk);
	endtask

	task do_reset(input logic opt);
		@(posedge pclk);
		presetn <= 0;
		option_byte <= {opt, 7'h00};
		ext_int_req <= 10'h000;
		int_level_req <= 8'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
	endtask

	// length of the next reset pulse, 0 if none shows within 20 cycles
	task pulse_len();
		int w;
		w = 0;
		n = 0;
		while (sys_reset !== 1'b1 && w < 20) begin
			@(negedge pclk);
			w++;
		end
		while (sys_reset === 1'b1 && n < 40) begin
			n++;
			@(negedge pclk);
		end
	endtask

	task wait_wake();
		seen = 0;
		repeat (8) begin
			@(negedge pclk);
			if (cpu_wake === 1'b1) seen = 1;
		end
	endtask

	task drive_vdd(input logic [7:0] v);
		@(posedge pclk);
		vdd_level <= v;
		repeat (2) @(negedge pclk);
	endtask

	task stop_armed();
		apb(1, ADDR_STOP_KEY, 32'h0000_00A5);
		op(STOP_OP);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_regs();
		do_reset(0);
		apb(0, ADDR_STOP_KEY, 0);
		check(d, 32'h0);
		apb(0, ADDR_STATUS, 0);
		check(d, 32'h0);
		apb(0, 8'h10, 0);
		check(32'(e), 32'h1);
		apb(1, ADDR_STOP_KEY, 32'h0000_005A);
		op(STOP_OP);
		check(32'(mode), 32'(MODE_RUN));
	endtask

	task t_stop_opt0();
		apb(1, ADDR_CLK_CTRL, 32'h0000_0018);
		stop_armed();
		check(32'(mode), 32'(MODE_STOP));
		check({osc_en, lvd_enable, internal_power_on_reset_enable}, 32'h1);
		drive_vdd(8'h06);
		drive_vdd(8'h0A);
		pulse_len();
		check(32'(n), 32'h0);
		check(32'(mode), 32'(MODE_STOP));
		ext_int_en <= 10'h200;
		ext_int_req <= 10'h200;
		pulse_len();
		check(32'(n), 32'h10);
		check(32'(mode), 32'(MODE_RUN));
		ext_int_req <= 10'h000;
		apb(0, ADDR_STOP_KEY, 0);
		check(d, 32'h0);
		check(32'(clkdiv_sel), 32'h0);
	endtask

	task t_port_and_por();
		stop_armed();
		port2_hi_in <= 4'h7;
		pulse_len();
		check(32'(n), 32'h10);
		port2_hi_in <= 4'hF;
		stop_armed();
		drive_vdd(8'h02);
		drive_vdd(8'h0A);
		pulse_len();
		check(32'(n), 32'h10);
	endtask

	task t_idle();
		apb(1, ADDR_INT_MASK, 32'h0);
		apb(1, ADDR_CLK_CTRL, 32'h0000_0018);
		op(IDLE_OPCODE);
		check({cpu_clk_en, periph_clk_en, port_dir_hold}, 32'h3);
		int_level_req <= 8'h04;
		repeat (4) @(negedge pclk);
		check(32'(mode), 32'(MODE_IDLE));
		apb(1, ADDR_INT_MASK, 32'h0000_0004);
		wait_wake();
		check(32'(seen), 32'h1);
		check({30'h0, clkdiv_sel}, 32'h3);
		int_level_req <= 8'h00;
	endtask

	task t_backup();
		@(posedge pclk);
		pin_assert <= 1;
		repeat (3) @(negedge pclk);
		check(32'(mode), 32'(MODE_BACKUP));
		wdt_overflow <= 1;
		ext_int_req <= 10'h200;
		@(posedge pclk);
		wdt_overflow <= 0;
		pulse_len();
		check(32'(n), 32'h0);
		ext_int_req <= 10'h000;
		drive_vdd(8'h06);
		pin_assert <= 0;
		pulse_len();
		check(32'(n), 32'h0);
		vdd_level <= 8'h0A;
		pulse_len();
		check(32'(n), 32'h10);
	endtask

	task t_opt1();
		do_reset(1);
		apb(0, ADDR_STATUS, 0);
		check(d & 32'h4, 32'h4);
		apb(1, ADDR_INT_MASK, 32'h0000_00FF);
		stop_armed();
		check(32'(lvd_enable), 32'h1);
		int_level_req <= 8'h01;
		repeat (4) @(negedge pclk);
		check(32'(mode), 32'(MODE_STOP));
		int_level_req <= 8'h00;
		ext_int_req <= 10'h001;
		ext_int_en <= 10'h001;
		wait_wake();
		check(32'(seen), 32'h1);
		pulse_len();
		check(32'(n), 32'h0);
		ext_int_req <= 10'h000;
		stop_armed();
		drive_vdd(8'h06);
		check(32'(mode), 32'(MODE_BACKUP));
		vdd_level <= 8'h0A;
		pulse_len();
		check(32'(n), 32'h10);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// whole run is a few hundred cycles; the limit of 20000 cycles leaves wide margin
	initial begin
		#(25 * 20000);
		err_count++;
		close_out();
	end

	initial begin
		t_regs();
		t_stop_opt0();
		t_port_and_por();
		t_idle();
		t_backup();
		t_opt1();
		close_out();
	end
endmodule
